// File: cbwd_pkg.sv
package cbwd_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned WORD_LSB = 2;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LAT_W = 8;
  localparam int unsigned N_WIN = 2;
  localparam int unsigned REG_N = 10;
  localparam int unsigned SLOT_STRIDE = 2;
  localparam int unsigned PREF0_BIT = 8;
  localparam int unsigned PREF1_BIT = 9;

  typedef logic [3:0] cbwd_slot_t;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LAT = 8'h1B;
  localparam logic [IDX_W-1:0] IDX_MEM0_BOT = 8'h1C;
  localparam logic [IDX_W-1:0] IDX_MEM0_TOP = 8'h20;
  localparam logic [IDX_W-1:0] IDX_MEM1_BOT = 8'h24;
  localparam logic [IDX_W-1:0] IDX_MEM1_TOP = 8'h28;
  localparam logic [IDX_W-1:0] IDX_IO0_BOT = 8'h2C;
  localparam logic [IDX_W-1:0] IDX_IO0_TOP = 8'h30;
  localparam logic [IDX_W-1:0] IDX_IO1_BOT = 8'h34;
  localparam logic [IDX_W-1:0] IDX_IO1_TOP = 8'h38;
  localparam logic [IDX_W-1:0] IDX_BCTL = 8'h3E;

  localparam cbwd_slot_t SLOT_LAT = 4'h0;
  localparam cbwd_slot_t SLOT_MEM0_BOT = 4'h1;
  localparam cbwd_slot_t SLOT_MEM0_TOP = 4'h2;
  localparam cbwd_slot_t SLOT_MEM1_BOT = 4'h3;
  localparam cbwd_slot_t SLOT_MEM1_TOP = 4'h4;
  localparam cbwd_slot_t SLOT_IO0_BOT = 4'h5;
  localparam cbwd_slot_t SLOT_IO0_TOP = 4'h6;
  localparam cbwd_slot_t SLOT_IO1_BOT = 4'h7;
  localparam cbwd_slot_t SLOT_IO1_TOP = 4'h8;
  localparam cbwd_slot_t SLOT_BCTL = 4'h9;
  localparam cbwd_slot_t SLOT_NONE = 4'hF;

  localparam logic [DATA_W-1:0] LAT_MASK = 32'h000000FF;
  localparam logic [DATA_W-1:0] MEM_MASK = 32'hFFFFF000;
  localparam logic [DATA_W-1:0] IO_BOT_MASK = 32'hFFFFFFFC;
  localparam logic [DATA_W-1:0] IO_TOP_MASK = 32'h0000FFFC;
  localparam logic [DATA_W-1:0] BCTL_MASK = 32'h00000300;
  localparam logic [DATA_W-1:0] REG_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] BCTL_RST = 32'h00000300;
  localparam logic [DATA_W-1:0] MEM_LOW_ONES = 32'h00000FFF;
  localparam logic [DATA_W-1:0] IO_LOW_ONES = 32'h00000003;
  localparam logic [DATA_W-1:0] IO_PAGE_MASK = 32'hFFFF0000;
  localparam logic [DATA_W-1:0] IO_OFS_MASK = 32'h0000FFFF;
  localparam logic [LAT_W-1:0] LAT_ZERO = 8'h00;
  localparam logic [LAT_W-1:0] LAT_ONE = 8'h01;

  typedef enum logic [1:0] {
    LAT_IDLE = 2'b00,
    LAT_RUN = 2'b01,
    LAT_EXPIRED = 2'b10
  } cbwd_lat_state_t;
endpackage

// File: cbwd_win_if.sv
interface cbwd_win_if;
  logic en;
  logic [cbwd_pkg::DATA_W-1:0] lo;
  logic [cbwd_pkg::DATA_W-1:0] hi;
  logic hit_dn;
  logic hit_up;
  modport owner (output en, output lo, output hi, input hit_dn, input hit_up);
  modport matcher (input en, input lo, input hi, output hit_dn, output hit_up);
endinterface

// File: cbwd_win_match.sv
module cbwd_win_match (
  input wire logic [cbwd_pkg::DATA_W-1:0] addr_dn,
  input wire logic [cbwd_pkg::DATA_W-1:0] addr_up,
  cbwd_win_if.matcher win
);
  import cbwd_pkg::*;

  // Inclusive range, gated by the window enable
  function automatic logic in_window(input logic [DATA_W-1:0] a, input logic en,
                                     input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
    return en && (a >= lo) && (a <= hi);
  endfunction

  assign win.hit_dn = in_window(addr_dn, win.en, win.lo, win.hi);
  assign win.hit_up = in_window(addr_up, win.en, win.lo, win.hi);
endmodule // cbwd_win_match

// File: cbwd_lat_timer.sv
module cbwd_lat_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [cbwd_pkg::LAT_W-1:0] lat_count,
  input wire logic cb_clk,
  input wire logic cb_frame_n,
  input wire logic cb_data_done,
  output logic lat_expired,
  output logic lat_terminate
);
  import cbwd_pkg::*;

  cbwd_lat_state_t state_q, state_d;
  logic [LAT_W-1:0] cnt_q, cnt_d;
  logic clk_prev_q;
  logic frame_prev_n_q;
  wire cclk_tick = cb_clk & ~clk_prev_q;
  wire frame_start = frame_prev_n_q & ~cb_frame_n;
  wire cnt_zero = (cnt_q == LAT_ZERO);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      LAT_IDLE: begin
        if (frame_start) begin
          cnt_d = lat_count;
          state_d = LAT_RUN;
        end
      end
      LAT_RUN: begin
        if (cb_frame_n) begin
          state_d = LAT_IDLE;
        end else if (cnt_zero) begin
          state_d = LAT_EXPIRED;
        end else if (cclk_tick) begin
          cnt_d = cnt_q - LAT_ONE;
        end
      end
      LAT_EXPIRED: begin
        // Ends with the data phase it cut short, or with the frame itself
        if (cb_frame_n || cb_data_done) begin
          state_d = LAT_IDLE;
        end
      end
      default: state_d = LAT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LAT_IDLE;
      cnt_q <= LAT_ZERO;
      clk_prev_q <= 1'b0;
      frame_prev_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      clk_prev_q <= cb_clk;
      frame_prev_n_q <= cb_frame_n;
    end
  end

  assign lat_expired = (state_q == LAT_EXPIRED);
  assign lat_terminate = lat_expired & cb_data_done & ~cb_frame_n;

  a_lat_reload_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == LAT_IDLE && frame_start) |=> (state_q == LAT_RUN && cnt_q == $past(lat_count)))
    else $error("latency count not loaded at frame start");
  a_lat_count_down: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == LAT_RUN && !cb_frame_n && !cnt_zero && cclk_tick) |=> (cnt_q == $past(cnt_q) - LAT_ONE))
    else $error("latency count did not step on card clock");
  a_lat_count_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == LAT_RUN && !cb_frame_n && !cclk_tick) |=> $stable(cnt_q))
    else $error("latency count moved without card clock");
  a_lat_run_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == LAT_RUN && cnt_zero && !cb_frame_n) |=> (lat_expired && (!cb_data_done || lat_terminate)))
    else $error("expiry not followed by termination request");
endmodule // cbwd_lat_timer

// File: cbwd_window_decode.sv
// Contract
// - Hold programmed latency count in card clocks
// - Frame start loads and starts latency counter
// - Expired counter ends transfer after data phase
// - Memory bottom gives window's lowest address
// - Memory top gives window's highest address
// - Memory windows also steer card cycles upstream
// - Memory bits 31-12 writable, 4K placement
// - Memory bits 11-0 read zero, writes ignored
// - Both memory registers zero: window claims nothing
// - Bridge control bits 8, 9 give prefetch
// - I/O bottom gives lowest I/O address
// - I/O low half offset, high half page
// - I/O bottom bits 31-2 writable, 1-0 zero
// - I/O window needs nonzero bottom or top
// - Latency and window registers reset to zero
// - I/O top upper half zero, low bits ones; here bits 1-0 read zero, ones only in the window match
// - Prefetch bit one prefetchable, resets to one
module cbwd_window_decode (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cbwd_pkg::ADDR_W-1:0] paddr,
  input wire logic [cbwd_pkg::DATA_W-1:0] pwdata,
  input wire logic [cbwd_pkg::STRB_W-1:0] pstrb,
  output logic pready,
  output logic [cbwd_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic dn_req,
  input wire logic [cbwd_pkg::DATA_W-1:0] dn_addr,
  input wire logic dn_is_io,
  output logic dn_ack,
  output logic dn_claim,
  output logic dn_window,
  output logic dn_prefetch,
  input wire logic up_req,
  input wire logic [cbwd_pkg::DATA_W-1:0] up_addr,
  input wire logic up_is_io,
  output logic up_ack,
  output logic up_forward,
  input wire logic cb_clk,
  input wire logic cb_frame_n,
  input wire logic cb_data_done,
  output logic lat_expired,
  output logic lat_terminate
);
  import cbwd_pkg::*;

  function automatic logic [4:0] reg_decode(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_LAT: return {1'b1, SLOT_LAT};
      IDX_MEM0_BOT: return {1'b1, SLOT_MEM0_BOT};
      IDX_MEM0_TOP: return {1'b1, SLOT_MEM0_TOP};
      IDX_MEM1_BOT: return {1'b1, SLOT_MEM1_BOT};
      IDX_MEM1_TOP: return {1'b1, SLOT_MEM1_TOP};
      IDX_IO0_BOT: return {1'b1, SLOT_IO0_BOT};
      IDX_IO0_TOP: return {1'b1, SLOT_IO0_TOP};
      IDX_IO1_BOT: return {1'b1, SLOT_IO1_BOT};
      IDX_IO1_TOP: return {1'b1, SLOT_IO1_TOP};
      IDX_BCTL: return {1'b1, SLOT_BCTL};
      default: return {1'b0, SLOT_NONE};
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] write_mask(input cbwd_slot_t slot);
    case (slot)
      SLOT_LAT: return LAT_MASK;
      SLOT_MEM0_BOT, SLOT_MEM0_TOP, SLOT_MEM1_BOT, SLOT_MEM1_TOP: return MEM_MASK;
      SLOT_IO0_BOT, SLOT_IO1_BOT: return IO_BOT_MASK;
      SLOT_IO0_TOP, SLOT_IO1_TOP: return IO_TOP_MASK;
      SLOT_BCTL: return BCTL_MASK;
      default: return REG_RST;
    endcase
  endfunction

  // Byte lanes and read-only bits both keep the old value
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wd,
                                              input logic [STRB_W-1:0] strb, input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] keep;
    keep = REG_RST;
    for (int b = 0; b < STRB_W; b++) begin
      keep[b*BYTE_W +: BYTE_W] = {BYTE_W{strb[b]}};
    end
    keep = keep & mask;
    return (old & ~keep) | (wd & keep);
  endfunction

  logic [DATA_W-1:0] regs_q [REG_N];
  logic [DATA_W-1:0] prdata_q;
  logic pslverr_q;
  logic dn_ack_q, dn_claim_q, dn_window_q, dn_prefetch_q;
  logic up_ack_q, up_forward_q;

  // Register bus decode
  wire [IDX_W-1:0] addr_idx = paddr[ADDR_W-1:WORD_LSB];
  wire [4:0] addr_dec = reg_decode(addr_idx);
  wire addr_hit = addr_dec[4];
  wire cbwd_slot_t addr_slot = addr_dec[3:0];
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire wr_en = apb_access & pwrite & addr_hit;
  wire [DATA_W-1:0] wr_value = merge(regs_q[addr_slot], pwdata, pstrb, write_mask(addr_slot));
  wire [DATA_W-1:0] rd_value = addr_hit ? regs_q[addr_slot] : REG_RST;

  // Read data is sampled in setup, so the access phase never waits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= REG_RST;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= rd_value;
      pslverr_q <= ~addr_hit;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_N; i++) begin
        regs_q[i] <= (i == SLOT_BCTL) ? BCTL_RST : REG_RST;
      end
    end else if (wr_en) begin
      regs_q[addr_slot] <= wr_value;
    end
  end

  assign pready = apb_access;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Window bounds and matching
  logic [N_WIN-1:0] mem_hit_dn, mem_hit_up, io_hit_dn, io_hit_up, mem_en, io_en;
  wire [N_WIN-1:0] pref_bits = {regs_q[SLOT_BCTL][PREF1_BIT], regs_q[SLOT_BCTL][PREF0_BIT]};

  for (genvar w = 0; w < N_WIN; w++) begin : g_win
    localparam cbwd_slot_t MB = cbwd_slot_t'(SLOT_MEM0_BOT + SLOT_STRIDE * w);
    localparam cbwd_slot_t MT = cbwd_slot_t'(SLOT_MEM0_TOP + SLOT_STRIDE * w);
    localparam cbwd_slot_t IB = cbwd_slot_t'(SLOT_IO0_BOT + SLOT_STRIDE * w);
    localparam cbwd_slot_t IT = cbwd_slot_t'(SLOT_IO0_TOP + SLOT_STRIDE * w);
    cbwd_win_if mem_if ();
    cbwd_win_if io_if ();

    assign mem_if.en = (regs_q[MB] != REG_RST) || (regs_q[MT] != REG_RST);
    assign mem_if.lo = regs_q[MB];
    assign mem_if.hi = regs_q[MT] | MEM_LOW_ONES;
    assign io_if.en = (regs_q[IB] != REG_RST) || (regs_q[IT] != REG_RST);
    assign io_if.lo = regs_q[IB];
    // Page always from the bottom; top only moves the offset
    assign io_if.hi = (regs_q[IB] & IO_PAGE_MASK) | (regs_q[IT] & IO_OFS_MASK) | IO_LOW_ONES;

    cbwd_win_match u_mem_match (
      .addr_dn(dn_addr),
      .addr_up(up_addr),
      .win(mem_if.matcher)
    );
    cbwd_win_match u_io_match (
      .addr_dn(dn_addr),
      .addr_up(up_addr),
      .win(io_if.matcher)
    );

    assign mem_hit_dn[w] = mem_if.hit_dn;
    assign mem_hit_up[w] = mem_if.hit_up;
    assign io_hit_dn[w] = io_if.hit_dn;
    assign io_hit_up[w] = io_if.hit_up;
    assign mem_en[w] = mem_if.en;
    assign io_en[w] = io_if.en;
  end

  // Window 0 wins where the two overlap
  wire [N_WIN-1:0] dn_hits = dn_is_io ? io_hit_dn : mem_hit_dn;
  wire dn_claim_d = |dn_hits;
  wire dn_window_d = ~dn_hits[0] & dn_hits[1];
  wire dn_prefetch_d = ~dn_is_io & dn_claim_d & pref_bits[dn_window_d];
  // Card cycles inside a window stay on the card side
  wire up_forward_d = up_is_io ? ~(|io_hit_up) : ~(|mem_hit_up);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dn_ack_q <= 1'b0;
      dn_claim_q <= 1'b0;
      dn_window_q <= 1'b0;
      dn_prefetch_q <= 1'b0;
    end else begin
      dn_ack_q <= dn_req;
      if (dn_req) begin
        dn_claim_q <= dn_claim_d;
        dn_window_q <= dn_window_d;
        dn_prefetch_q <= dn_prefetch_d;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_ack_q <= 1'b0;
      up_forward_q <= 1'b0;
    end else begin
      up_ack_q <= up_req;
      if (up_req) begin
        up_forward_q <= up_forward_d;
      end
    end
  end

  assign dn_ack = dn_ack_q;
  assign dn_claim = dn_claim_q;
  assign dn_window = dn_window_q;
  assign dn_prefetch = dn_prefetch_q;
  assign up_ack = up_ack_q;
  assign up_forward = up_forward_q;

  // Count is read once per frame; a rewrite mid-frame waits for the next one
  cbwd_lat_timer u_lat (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lat_count(regs_q[SLOT_LAT][LAT_W-1:0]),
    .cb_clk(cb_clk),
    .cb_frame_n(cb_frame_n),
    .cb_data_done(cb_data_done),
    .lat_expired(lat_expired),
    .lat_terminate(lat_terminate)
  );

  a_lat_reg_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && addr_slot == SLOT_LAT && pstrb[0]) |=> (regs_q[SLOT_LAT] == ($past(pwdata) & LAT_MASK)))
    else $error("latency count write lost");
  a_mem_write_take: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && addr_slot == SLOT_MEM0_BOT && pstrb == 4'hF) |=> (regs_q[SLOT_MEM0_BOT] == ($past(pwdata) & MEM_MASK)))
    else $error("memory bottom write not taken");
  a_mem_low_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (apb_setup && !pwrite && addr_hit && write_mask(addr_slot) == MEM_MASK) |=> ((prdata & ~MEM_MASK) == REG_RST))
    else $error("memory register low bits not zero");
  a_io_low_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && addr_slot == SLOT_IO1_BOT && pstrb == 4'hF) |=> (regs_q[SLOT_IO1_BOT] == ($past(pwdata) & IO_BOT_MASK)))
    else $error("io bottom write not masked");
  a_mem_off_claim: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dn_req && !dn_is_io && mem_en == 2'b00) |=> !dn_claim)
    else $error("disabled memory window claimed");
  a_io_off_claim: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dn_req && dn_is_io && io_en == 2'b00) |=> !dn_claim)
    else $error("disabled io window claimed");
  a_mem_top_incl: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dn_req && !dn_is_io && mem_en[0] && dn_addr == (regs_q[SLOT_MEM0_TOP] | MEM_LOW_ONES)
     && regs_q[SLOT_MEM0_BOT] <= dn_addr) |=> (dn_claim && !dn_window))
    else $error("memory window top not inclusive");
  a_io_page_check: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dn_req && dn_is_io && !io_hit_dn[1]
     && (dn_addr & IO_PAGE_MASK) != (regs_q[SLOT_IO0_BOT] & IO_PAGE_MASK)) |=> !dn_claim)
    else $error("io claim outside page");
  a_prefetch_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dn_req && !dn_is_io && mem_hit_dn[0]) |=> (dn_prefetch == $past(regs_q[SLOT_BCTL][PREF0_BIT])))
    else $error("prefetch attribute not from its bit");
  a_up_inside_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    (up_req && !up_is_io && mem_hit_up != 2'b00) |=> (up_ack && !up_forward))
    else $error("card cycle inside window sent upstream");
endmodule // cbwd_window_decode

// File: cbwd_card_model.sv
module cbwd_card_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] len,
  output logic cb_clk,
  output logic cb_frame_n,
  output logic cb_data_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act_q;
  logic [2:0] ph_q;
  logic [7:0] tk_q;
  wire logic [2:0] half_w = slow ? 3'h5 : 3'h2;
  // Card clock still outside frames; one data phase per card clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= 1'b0;
      ph_q <= 3'h0;
      tk_q <= 8'h00;
      cb_clk <= 1'b0;
      cb_frame_n <= 1'b1;
      cb_data_done <= 1'b0;
    end else begin
      cb_data_done <= 1'b0;
      if (go && !act_q) begin
        act_q <= 1'b1;
        cb_frame_n <= 1'b0;
        ph_q <= 3'h0;
        tk_q <= 8'h00;
      end else if (act_q) begin
        ph_q <= ph_q + 3'h1;
        if (ph_q == half_w) begin
          ph_q <= 3'h0;
          cb_clk <= ~cb_clk;
          if (!cb_clk) begin
            tk_q <= tk_q + 8'h01;
            cb_data_done <= 1'b1;
          end
          // Frame released on the falling card clock after the last phase
          if (cb_clk && tk_q == len) begin
            act_q <= 1'b0;
            cb_frame_n <= 1'b1;
          end
        end
      end
    end
  end
endmodule // cbwd_card_model

// File: test_cardbus_window_decode.sv
module test_cardbus_window_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import cbwd_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, dn_addr, up_addr;
  logic [STRB_W-1:0] pstrb;
  logic dn_req, dn_is_io, dn_ack, dn_claim, dn_window, dn_prefetch, up_req, up_is_io, up_ack, up_forward;
  logic cb_clk, cb_frame_n, cb_data_done, lat_expired, lat_terminate, go, slow, ex_q, fr_q, ck_q;
  logic [7:0] len;
  logic [32:0] rd_q[$], dn_q[$], up_q[$], lat_q[$];
  logic [7:0] rst_idx[10] = '{IDX_LAT, IDX_MEM0_BOT, IDX_MEM0_TOP, IDX_MEM1_BOT, IDX_MEM1_TOP,
                              IDX_IO0_BOT, IDX_IO0_TOP, IDX_IO1_BOT, IDX_IO1_TOP, IDX_BCTL};
  int fails, cmp_count, cyc, tk, tc;

  cbwd_window_decode uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .dn_req(dn_req), .dn_addr(dn_addr), .dn_is_io(dn_is_io), .dn_ack(dn_ack),
    .dn_claim(dn_claim), .dn_window(dn_window), .dn_prefetch(dn_prefetch), .up_req(up_req),
    .up_addr(up_addr), .up_is_io(up_is_io), .up_ack(up_ack), .up_forward(up_forward), .cb_clk(cb_clk),
    .cb_frame_n(cb_frame_n), .cb_data_done(cb_data_done), .lat_expired(lat_expired),
    .lat_terminate(lat_terminate));
  cbwd_card_model card (.core_clk(core_clk), .rst_n(rst_n), .go(go), .slow(slow), .len(len),
    .cb_clk(cb_clk), .cb_frame_n(cb_frame_n), .cb_data_done(cb_data_done));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task chk(input string nm, input logic [32:0] s, input logic [32:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task tally_and_finish;
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Request held until pready is sampled; released by the next caller
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [32:0] e);
    dn_req <= 1'b0;
    up_req <= 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    if (!w) rd_q.push_back(e);
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
  endtask

  task q(input logic up, input logic io, input logic [31:0] a, input logic [2:0] e);
    psel <= 1'b0;
    penable <= 1'b0;
    dn_req <= !up;
    up_req <= up;
    dn_is_io <= io;
    up_is_io <= io;
    dn_addr <= a;
    up_addr <= a;
    if (up) up_q.push_back({32'h0, e[0]});
    else dn_q.push_back({30'h0, e});
    @(posedge core_clk);
  endtask

  task frame(input logic [7:0] v, input logic s);
    apb(1'b1, IDX_LAT, {24'hFFFFFF, v}, 33'h0);
    apb(1'b0, IDX_LAT, 32'h0, {25'h0, v});
    psel <= 1'b0;
    penable <= 1'b0;
    go <= 1'b1;
    slow <= s;
    len <= v + 8'h02;
    lat_q.push_back({25'h0, v});
    @(posedge core_clk);
    go <= 1'b0;
    do @(posedge core_clk); while (!cb_frame_n);
    @(posedge core_clk);
    // Every frame here outlives its count, so exactly one cut is due
    chk("terms", tc, 33'h1);
  endtask

  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0)
      chk("read", {pslverr, prdata}, rd_q.pop_front());
    if (dn_ack && dn_q.size() > 0)
      chk("down", {dn_claim, dn_window, dn_prefetch}, dn_q.pop_front());
    if (up_ack && up_q.size() > 0)
      chk("up", up_forward, up_q.pop_front());
    if (lat_expired && !ex_q && lat_q.size() > 0)
      chk("ticks", tk, lat_q.pop_front());
    if (!cb_frame_n && lat_expired && cb_data_done) chk("end", lat_terminate, 1'b1);
    if (!lat_expired) chk("no end", lat_terminate, 1'b0);
    // Compare before counting: a tick on this edge is not yet seen by the counter
    tk = (fr_q && !cb_frame_n) ? 0 : tk + ((cb_clk && !ck_q) ? 1 : 0);
    tc = (fr_q && !cb_frame_n) ? 0 : tc + ((lat_terminate === 1'b1) ? 1 : 0);
    ex_q = lat_expired;
    fr_q = cb_frame_n;
    ck_q = cb_clk;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, dn_req, dn_is_io, up_req, up_is_io, go, slow, ex_q, ck_q} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    dn_addr = '0;
    up_addr = '0;
    len = 8'h00;
    fr_q = 1'b1;
    {fails, cmp_count, cyc, tk, tc} = '0;
    void'($urandom(59617));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rst_idx[i]) apb(1'b0, rst_idx[i], 32'h0, {1'b0, (i == 9) ? BCTL_RST : REG_RST});
    q(1'b0, 1'b0, 32'h0, 3'h0);
    q(1'b0, 1'b1, 32'h0, 3'h0);
    q(1'b1, 1'b0, 32'h0, 3'h1);
    apb(1'b1, IDX_MEM0_BOT, 32'h10000ABC, 33'h0);
    apb(1'b0, IDX_MEM0_BOT, 32'h0, {1'b0, 32'h10000000});
    apb(1'b1, IDX_MEM0_TOP, 32'h1000F000, 33'h0);
    apb(1'b1, IDX_MEM1_BOT, 32'h20000000, 33'h0);
    apb(1'b1, IDX_MEM1_TOP, 32'h20000FFF, 33'h0);
    q(1'b0, 1'b0, 32'h10000000, 3'h5);
    q(1'b0, 1'b0, 32'h1000FFFF, 3'h5);
    q(1'b0, 1'b0, 32'h10010000, 3'h0);
    q(1'b0, 1'b0, 32'h0FFFFFFF, 3'h0);
    q(1'b0, 1'b0, 32'h10000000 + ($urandom % 32'h10000), 3'h5);
    q(1'b0, 1'b0, 32'h20000FFF, 3'h7);
    q(1'b0, 1'b0, 32'h20001000, 3'h0);
    q(1'b1, 1'b0, 32'h10008000, 3'h0);
    q(1'b1, 1'b0, 32'h30000000, 3'h1);
    apb(1'b1, IDX_BCTL, 32'h00000100, 33'h0);
    q(1'b0, 1'b0, 32'h20000000, 3'h6);
    apb(1'b1, IDX_BCTL, 32'h00000200, 33'h0);
    q(1'b0, 1'b0, 32'h10000000, 3'h4);
    apb(1'b1, IDX_IO0_BOT, 32'h00120102, 33'h0);
    apb(1'b0, IDX_IO0_BOT, 32'h0, {1'b0, 32'h00120100});
    apb(1'b1, IDX_IO0_TOP, 32'hFFFF020C, 33'h0);
    apb(1'b0, IDX_IO0_TOP, 32'h0, {1'b0, 32'h0000020C});
    q(1'b0, 1'b1, 32'h00120100, 3'h4);
    q(1'b0, 1'b1, 32'h0012020F, 3'h4);
    q(1'b0, 1'b1, 32'h00120210, 3'h0);
    q(1'b0, 1'b1, 32'h001200FC, 3'h0);
    q(1'b0, 1'b0, 32'h00120100, 3'h0);
    q(1'b1, 1'b1, 32'h00120104, 3'h0);
    apb(1'b1, IDX_IO1_BOT, 32'hABCD0003, 33'h0);
    q(1'b0, 1'b1, 32'hABCD0003, 3'h6);
    q(1'b0, 1'b1, 32'hABCD0004, 3'h0);
    apb(1'b1, IDX_MEM1_BOT, 32'hFFFFFFFF, 33'h0);
    apb(1'b0, IDX_MEM1_BOT, 32'h0, {1'b0, 32'hFFFFF000});
    apb(1'b0, 8'hFF, 32'h0, {1'b1, 32'h0});
    frame(8'h00, 1'b1);
    frame(8'h03, 1'b0);
    frame(8'h20, 1'b0);
    frame(8'h01 + 8'($urandom % 48), 1'b1);
    chk("queues", 33'(rd_q.size() + dn_q.size() + up_q.size() + lat_q.size()), 33'h0);
    tally_and_finish;
  end
endmodule // test_cardbus_window_decode
